// ===== src/aogt_trim_regs.v
// offset and fine gain trim register bank with data path selection
// Notes on behaviour
// - core A input A offset, single mode, calibration
// - core A input B offset, 90 degree phase
// - core B offsets per input, both modes
// - offset registers 16 bits, reserved high four
// - core A bank 0 dual gain, five bits
// - core A bank 1 dual gain, five bits
// - power-up values loaded from fuse storage
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "aogt_defines.vh"

module aogt_trim_regs
#(
  parameter OFS_REG_W  = 16,
  parameter GAIN_REG_W = 8,
  parameter NUM_OFS    = 4,
  parameter NUM_GAIN   = 2
)
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // register port
  input  wire [11:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // fuse defaults, sampled while rst is high
  input  wire [15:0] fuse_ofs_a_in_a,
  input  wire [15:0] fuse_ofs_a_in_b,
  input  wire [15:0] fuse_ofs_b_in_a,
  input  wire [15:0] fuse_ofs_b_in_b,
  input  wire [7:0]  fuse_gain_a0,
  input  wire [7:0]  fuse_gain_a1,
  // operating mode
  input  wire        single_mode,
  input  wire        fg_cal_en,
  input  wire        core_a_on_in_b,
  input  wire        core_b_on_in_b,
  input  wire        sample_en,
  // data path trims
  output reg  [11:0] core_a_offset,
  output reg         core_a_offset_vld,
  output reg  [11:0] core_b_offset,
  output reg         core_b_offset_vld,
  output reg  [4:0]  core_a_bank0_gain,
  output reg  [4:0]  core_a_bank1_gain,
  output reg         core_a_gain_vld
);

  // entry order inside the bank, shared by storage, decode and readback
  localparam IDX_A_IN_A = 0;
  localparam IDX_A_IN_B = 1;
  localparam IDX_B_IN_A = 2;
  localparam IDX_B_IN_B = 3;
  localparam IDX_G0     = 0;
  localparam IDX_G1     = 1;
  // field split of each entry: correction value low, reserved high
  localparam OFS_VAL_W  = `AOGT_OFS_MSB + 1;
  localparam OFS_RSV_W  = OFS_REG_W - OFS_VAL_W;
  localparam GAIN_VAL_W = `AOGT_GAIN_MSB + 1;
  localparam GAIN_RSV_W = GAIN_REG_W - GAIN_VAL_W;
  localparam OFS_TOT_W  = NUM_OFS * OFS_REG_W;
  localparam GAIN_TOT_W = NUM_GAIN * GAIN_REG_W;

  // fuse defaults and entry addresses, packed per entry
  wire [OFS_TOT_W-1:0]   fuse_ofs_all;
  wire [GAIN_TOT_W-1:0]  fuse_gain_all;
  wire [NUM_OFS*12-1:0]  ofs_addr_all;
  wire [NUM_GAIN*12-1:0] gain_addr_all;
  // live register contents, packed per entry
  wire [OFS_TOT_W-1:0]   ofs_all;
  wire [GAIN_TOT_W-1:0]  gain_all;
  // decoded hits
  wire [NUM_OFS-1:0]     ofs_hit;
  wire [NUM_GAIN-1:0]    gain_hit;
  // read path
  reg  [15:0]            rdata_d;
  // next values of the data path outputs
  reg  [11:0]            core_a_offset_d;
  reg                    core_a_offset_vld_d;
  reg  [11:0]            core_b_offset_d;
  reg                    core_b_offset_vld_d;
  reg  [4:0]             core_a_bank0_gain_d;
  reg  [4:0]             core_a_bank1_gain_d;
  reg                    core_a_gain_vld_d;
  // mode qualifiers
  wire                   a_in_a_live;
  wire                   a_in_b_live;
  wire                   b_live;
  wire                   gain_live;

  // the highest entry sits in the top slice of each packed vector
  assign fuse_ofs_all  = {fuse_ofs_b_in_b, fuse_ofs_b_in_a,
                          fuse_ofs_a_in_b, fuse_ofs_a_in_a};
  assign fuse_gain_all = {fuse_gain_a1, fuse_gain_a0};
  assign ofs_addr_all  = {`AOGT_OFF_B_IN_B, `AOGT_OFF_B_IN_A,
                          `AOGT_OFF_A_SGL_IN_B, `AOGT_OFF_A_SGL_IN_A};
  assign gain_addr_all = {`AOGT_OFF_GAIN_A1, `AOGT_OFF_GAIN_A0};

  genvar gi;

  // one storage word per offset entry; fuse values are captured on
  // every clock of reset, so no port reaches a flop asynchronously
  generate
    for (gi = 0; gi < NUM_OFS; gi = gi + 1)
    begin : g_ofs
      reg  [OFS_VAL_W-1:0] val_q;
      reg  [OFS_RSV_W-1:0] rsv_q;
      wire                 wr_en;

      assign ofs_hit[gi] = reg_addr == ofs_addr_all[gi*12 +: 12];
      assign wr_en       = reg_wr & ofs_hit[gi];
      assign ofs_all[gi*OFS_REG_W +: OFS_REG_W] = {rsv_q, val_q};

      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          val_q <= fuse_ofs_all[gi*OFS_REG_W +: OFS_VAL_W];
          rsv_q <= fuse_ofs_all[gi*OFS_REG_W+OFS_VAL_W +: OFS_RSV_W];
        end
        else if (wr_en)
        begin
          val_q <= reg_wdata[OFS_VAL_W-1:0];
          // reserved bits are plain read/write storage
          rsv_q <= reg_wdata[OFS_REG_W-1:OFS_VAL_W];
        end
      end
    end
  endgenerate

  // one storage byte per gain bank; the high byte of a write is dropped
  generate
    for (gi = 0; gi < NUM_GAIN; gi = gi + 1)
    begin : g_gain
      reg  [GAIN_VAL_W-1:0] val_q;
      reg  [GAIN_RSV_W-1:0] rsv_q;
      wire                  wr_en;

      assign gain_hit[gi] = reg_addr == gain_addr_all[gi*12 +: 12];
      assign wr_en        = reg_wr & gain_hit[gi];
      assign gain_all[gi*GAIN_REG_W +: GAIN_REG_W] = {rsv_q, val_q};

      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          val_q <= fuse_gain_all[gi*GAIN_REG_W +: GAIN_VAL_W];
          rsv_q <= fuse_gain_all[gi*GAIN_REG_W+GAIN_VAL_W +: GAIN_RSV_W];
        end
        else if (wr_en)
        begin
          val_q <= reg_wdata[GAIN_VAL_W-1:0];
          rsv_q <= reg_wdata[GAIN_REG_W-1:GAIN_VAL_W];
        end
      end
    end
  endgenerate

  // unmapped addresses read as zero; gain registers read zero above
  // their byte
  always @*
  begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `AOGT_OFF_A_SGL_IN_A:
      begin
        rdata_d = ofs_all[IDX_A_IN_A*OFS_REG_W +: 16];
      end
      `AOGT_OFF_A_SGL_IN_B:
      begin
        rdata_d = ofs_all[IDX_A_IN_B*OFS_REG_W +: 16];
      end
      `AOGT_OFF_B_IN_A:
      begin
        rdata_d = ofs_all[IDX_B_IN_A*OFS_REG_W +: 16];
      end
      `AOGT_OFF_B_IN_B:
      begin
        rdata_d = ofs_all[IDX_B_IN_B*OFS_REG_W +: 16];
      end
      `AOGT_OFF_GAIN_A0:
      begin
        rdata_d = {8'h00, gain_all[IDX_G0*GAIN_REG_W +: 8]};
      end
      `AOGT_OFF_GAIN_A1:
      begin
        rdata_d = {8'h00, gain_all[IDX_G1*GAIN_REG_W +: 8]};
      end
      default:
      begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe, and reads
  // zero otherwise so a late sample cannot pick up stale data
  always @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 16'h0000;
  end

  // input A offset of core A only applies in single mode; input B is
  // taken on the 90 degree phase in either mode
  assign a_in_a_live = fg_cal_en & single_mode & ~core_a_on_in_b;
  assign a_in_b_live = fg_cal_en & core_a_on_in_b;
  // core B offsets apply in both modes
  assign b_live      = fg_cal_en;
  // bank gains belong to dual mode only
  assign gain_live   = ~single_mode;

  // next trims are picked from the live registers, so a write needs
  // no recalibration to be seen
  always @*
  begin
    core_a_offset_d = 12'h000;
    if (core_a_on_in_b)
    begin
      core_a_offset_d = ofs_all[IDX_A_IN_B*OFS_REG_W +: OFS_VAL_W];
    end
    else
    begin
      core_a_offset_d = ofs_all[IDX_A_IN_A*OFS_REG_W +: OFS_VAL_W];
    end
  end

  // core B picks its trim by input alone
  always @*
  begin
    core_b_offset_d = 12'h000;
    if (core_b_on_in_b)
    begin
      core_b_offset_d = ofs_all[IDX_B_IN_B*OFS_REG_W +: OFS_VAL_W];
    end
    else
    begin
      core_b_offset_d = ofs_all[IDX_B_IN_A*OFS_REG_W +: OFS_VAL_W];
    end
  end

  // gains are passed on in every mode; the flag marks dual mode
  always @*
  begin
    core_a_bank0_gain_d = gain_all[IDX_G0*GAIN_REG_W +: GAIN_VAL_W];
  end

  always @*
  begin
    core_a_bank1_gain_d = gain_all[IDX_G1*GAIN_REG_W +: GAIN_VAL_W];
  end

  // a valid flag tells the data path whether to apply the trim at all
  always @*
  begin
    core_a_offset_vld_d = 1'b0;
    if (a_in_a_live)
      core_a_offset_vld_d = 1'b1;
    if (a_in_b_live)
      core_a_offset_vld_d = 1'b1;
  end

  always @*
  begin
    core_b_offset_vld_d = 1'b0;
    if (b_live)
      core_b_offset_vld_d = 1'b1;
  end

  always @*
  begin
    core_a_gain_vld_d = 1'b0;
    if (gain_live)
      core_a_gain_vld_d = 1'b1;
  end

  // the trims move only on a sample enable, so a write reaches the
  // data path at the next sample and never part way through one
  always @(posedge clk_sys)
  begin
    if (rst)
      core_a_offset <= 12'h000;
    else if (sample_en)
      core_a_offset <= core_a_offset_d;
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      core_a_offset_vld <= 1'b0;
    else if (sample_en)
      core_a_offset_vld <= core_a_offset_vld_d;
  end

  // core B outputs
  always @(posedge clk_sys)
  begin
    if (rst)
      core_b_offset <= 12'h000;
    else if (sample_en)
      core_b_offset <= core_b_offset_d;
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      core_b_offset_vld <= 1'b0;
    else if (sample_en)
      core_b_offset_vld <= core_b_offset_vld_d;
  end

  // bank gain outputs of core A
  always @(posedge clk_sys)
  begin
    if (rst)
      core_a_bank0_gain <= 5'h00;
    else if (sample_en)
      core_a_bank0_gain <= core_a_bank0_gain_d;
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      core_a_bank1_gain <= 5'h00;
    else if (sample_en)
      core_a_bank1_gain <= core_a_bank1_gain_d;
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      core_a_gain_vld <= 1'b0;
    else if (sample_en)
      core_a_gain_vld <= core_a_gain_vld_d;
  end

endmodule // aogt_trim_regs

// ===== include/aogt_defines.vh
// register offsets, field positions and reset values for the trim bank
`ifndef AOGT_DEFINES_VH
`define AOGT_DEFINES_VH

`define AOGT_ADDR_W          12
`define AOGT_OFF_A_SGL_IN_A  12'h348
`define AOGT_OFF_A_SGL_IN_B  12'h34a
`define AOGT_OFF_B_IN_A      12'h34c
`define AOGT_OFF_B_IN_B      12'h34e
`define AOGT_OFF_GAIN_A0     12'h350
`define AOGT_OFF_GAIN_A1     12'h351

`define AOGT_OFS_MSB         11
`define AOGT_RSV_OFS_MSB     15
`define AOGT_GAIN_MSB        4
`define AOGT_RSV_GAIN_MSB    7

`define AOGT_RST_OFS         16'h0000
`define AOGT_RST_GAIN        8'h00

`endif

// ===== tb/aogt_trim_regs_assertions.sv
// port assertions for the trim bank
`timescale 1ns/1ns
module aogt_chk (
  input wire        clk_sys, rst, reg_wr, reg_rd, sample_en,
  input wire        single_mode, fg_cal_en, core_a_on_in_b,
  input wire        core_b_on_in_b, core_a_offset_vld,
  input wire        core_b_offset_vld, core_a_gain_vld,
  input wire [11:0] reg_addr, core_b_offset,
  input wire [15:0] reg_wdata, reg_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("rdata not idle");
  a_gain_rsv_zero: assert property (reg_rd && reg_addr == 12'h350
    |=> reg_rdata[15:8] == 8'h0) else $error("gain high byte set");
  a_wr_rd_back: assert property (reg_wr && reg_addr == 12'h34c
    ##1 reg_rd && reg_addr == 12'h34c |=> reg_rdata == $past(reg_wdata, 2))
    else $error("readback wrong");
  a_wr_apply: assert property (reg_wr && reg_addr == 12'h34c
    ##1 sample_en && !reg_wr && !core_b_on_in_b
    |=> core_b_offset == $past(reg_wdata[11:0], 2)) else $error("no apply");
  a_a_vld: assert property (sample_en |=> core_a_offset_vld ==
    $past(fg_cal_en && (core_a_on_in_b || single_mode))) else $error("a vld");
  a_b_vld: assert property (sample_en
    |=> core_b_offset_vld == $past(fg_cal_en)) else $error("b vld");
  a_gain_vld: assert property (sample_en
    |=> core_a_gain_vld == !$past(single_mode)) else $error("gain vld");
  a_trim_hold: assert property (!sample_en
    |=> $stable(core_b_offset)) else $error("trim moved");
endmodule // aogt_chk
bind aogt_trim_regs aogt_chk u_chk (.*);

// ===== tb/aogt_trim_regs_tb.sv
// self-checking bench for the trim bank
`timescale 1ns/1ns
module aogt_trim_regs_tb;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, sample_en = 0;
  logic single_mode = 0, fg_cal_en = 0;
  logic core_a_on_in_b = 0, core_b_on_in_b = 0;
  logic [11:0] reg_addr = 12'h0;
  logic [15:0] reg_wdata = 16'h0, w;
  wire [15:0] reg_rdata;
  wire [11:0] core_a_offset, core_b_offset;
  wire [4:0]  core_a_bank0_gain, core_a_bank1_gain;
  wire        core_a_offset_vld, core_b_offset_vld, core_a_gain_vld;
  logic [11:0] ad [6] = '{12'h348, 12'h34a, 12'h34c, 12'h34e, 12'h350,
    12'h351};
  logic [15:0] fz [6] = '{16'h9abc, 16'h1234, 16'h0fed, 16'h5a5a,
    16'h001f, 16'h00ea};
  int miscompares = 0, cmp_count = 0;
  aogt_trim_regs u_dut (.*, .fuse_ofs_a_in_a(fz[0]), .fuse_ofs_a_in_b(fz[1]),
    .fuse_ofs_b_in_a(fz[2]), .fuse_ofs_b_in_b(fz[3]),
    .fuse_gain_a0(fz[4][7:0]), .fuse_gain_a1(fz[5][7:0]));
  initial forever #5 clk_sys = ~clk_sys;
  task chk(input [15:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [11:0] a, input [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input [11:0] a, input [15:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, e);
    @(posedge clk_sys);
  endtask
  task smp(input [3:0] m);
    {single_mode, fg_cal_en, core_a_on_in_b, core_b_on_in_b} <= m;
    sample_en <= 1'b1;
    @(posedge clk_sys);
    sample_en <= 1'b0;
    @(negedge clk_sys);
  endtask
  task t_regs;
    for (int i = 0; i < 6; i++)
      rd(ad[i], fz[i]);
    for (int i = 0; i < 6; i++)
    begin
      w = 16'hf3a0 + i[15:0];
      wr(ad[i], w);
      rd(ad[i], i < 4 ? w : w & 16'h00ff);
    end
    wr(12'h352, 16'hffff);
    rd(12'h352, 16'h0000);
  endtask
  task t_path;
    for (int m = 0; m < 16; m++)
    begin
      smp(m[3:0]);
      chk({13'h0, core_a_offset_vld, core_b_offset_vld, core_a_gain_vld},
        {13'h0, m[2] & (m[1] | m[3]), m[2], !m[3]});
      chk({4'h0, core_b_offset}, m[0] ? 16'h03a3 : 16'h03a2);
      if (m[2] & (m[1] | m[3]))
        chk({4'h0, core_a_offset}, m[1] ? 16'h03a1 : 16'h03a0);
      chk({6'h0, core_a_bank0_gain, core_a_bank1_gain}, 16'h0085);
      @(posedge clk_sys);
    end
    wr(12'h34c, 16'h0777);
    smp(4'h4);
    chk({4'h0, core_b_offset}, 16'h0777);
  endtask
  task end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_path;
    end_sim;
  end
  initial
  begin
    #20000;
    miscompares++;
    end_sim;
  end
endmodule // aogt_trim_regs_tb
